// ### tb/mcehf_burst_src.sv
// Modem-side burst source feeding the headend receiver
`timescale 1ns/100ps
`default_nettype none
module mcehf_burst_src (
  input wire logic sys_clk,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic burstStart
);
  initial
  begin
    rxByte = 8'h5a;
    rxValid = 1'b0;
    burstStart = 1'b0;
  end

  // Sends n bytes back to back, first byte in the highest used position
  task automatic send(input logic [255:0] d, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      #1;
      rxByte = d[8*(n-1-i) +: 8];
      rxValid = 1'b1;
      burstStart = (i == 0);
    end
    @(posedge sys_clk);
    #1;
    rxValid = 1'b0;
    burstStart = 1'b0;
    rxByte = ~rxByte;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the upstream burst receiver
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mcehf_pkg::*;
  typedef struct {
    logic dir;
    int n;
    logic [255:0] d;
    logic [7:0] frames;
    logic [7:0] err;
    logic [7:0] mask;
    int outs;
  } mcehf_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic dirDownstream = 1'b0;
  logic [7:0] rxByte, outByte, framesSeen, reqSlots, phsIndex, ugsByte, gotSlots, gotByte;
  logic rxValid, burstStart, outValid, outFrameStart, outFrameEnd, burstDone;
  logic reqValid, ackValid, phsValid, ugsValid;
  logic [15:0] reqSid, ackSid, gotSid;
  logic [ERR_WIDTH-1:0] errFlags;
  int fails = 0;
  int checked = 0;
  int outCnt, startCnt, doneCnt, reqCnt;
  int endCnt, ackCnt, phsCnt, ugsCnt;
  mcehf_row_t rows [10];

  always #25 sys_clk = ~sys_clk;

  mcehf_burst_src i_mcehf_burst_src (.sys_clk(sys_clk), .rxByte(rxByte), .rxValid(rxValid),
    .burstStart(burstStart));

  mcehf_rx_framer i_mcehf_rx_framer (.sys_clk(sys_clk), .rst_n(rst_n), .rxByte(rxByte),
    .rxValid(rxValid), .burstStart(burstStart), .dirDownstream(dirDownstream), .outByte(outByte),
    .outValid(outValid), .outFrameStart(outFrameStart), .outFrameEnd(outFrameEnd),
    .burstDone(burstDone), .framesSeen(framesSeen), .errFlags(errFlags), .reqValid(reqValid),
    .reqSlots(reqSlots), .reqSid(reqSid), .ackValid(ackValid), .ackSid(ackSid),
    .phsValid(phsValid), .phsIndex(phsIndex), .ugsValid(ugsValid), .ugsByte(ugsByte));

  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(negedge sys_clk)
  begin
    if (outValid === 1'b1) outCnt++;
    if (outFrameStart === 1'b1)
    begin
      if (startCnt == 0) gotByte = outByte;
      startCnt++;
    end
    if (outFrameEnd === 1'b1) endCnt++;
    if (burstDone === 1'b1) doneCnt++;
    if (ackValid === 1'b1) ackCnt++;
    if (phsValid === 1'b1) phsCnt++;
    if (ugsValid === 1'b1) ugsCnt++;
    if (reqValid === 1'b1)
    begin
      reqCnt++;
      gotSlots = reqSlots;
      gotSid = reqSid;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #(50 * 3000);
    fails++;
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rows = '{
      '{0, 18, 144'hf802000c0000c40512340000c40612340000, 2, 0, 8'hff, 12},
      '{0, 18, 144'hf803000c0000c40512340000c40612340000, 2, 8'h20, 8'hff, 12},
      '{0, 18, 144'hf800000c0000f80000060000c40512340000, 2, 8'h02, 8'hff, 12},
      '{0, 8, 64'hc1010002000000aa, 0, 8'h04, 8'h04, -1},
      '{0, 7, 56'hc30000010000aa, 0, 8'h08, 8'h08, -1},
      '{0, 6, 48'hf80000000000, 0, 8'h10, 8'h10, -1},
      '{0, 9, 72'hc30200030100_0000aa, 0, 8'h40, 8'h40, -1},
      '{1, 18, 144'hf802000c0000c40512340000c40612340000, 0, 8'h01, 8'h01, -1},
      '{0, 24, 192'hf80100120000c30b000c72aabb00f201001307abcd0000ee, 1, 0, 8'hff, 18},
      '{0, 29, 232'hf80200170000c30b000b34aabbccdd62093c2212340000c40512340000, 2, 0, 8'hff, 23}
    };
    repeat (12) @(posedge sys_clk);
    check("errFlags", 0, errFlags);
    #1;
    rst_n = 1'b1;
    foreach (rows[k])
    begin
      dirDownstream = rows[k].dir;
      outCnt = 0;
      startCnt = 0;
      doneCnt = 0;
      endCnt = 0;
      i_mcehf_burst_src.send(rows[k].d, rows[k].n);
      repeat (4) @(posedge sys_clk);
      #1;
      check("errFlags", rows[k].err, errFlags & rows[k].mask);
      if (rows[k].outs >= 0)
      begin
        check("framesSeen", rows[k].frames, framesSeen);
        check("outBytes", rows[k].outs, outCnt);
        check("frameStarts", rows[k].frames, startCnt);
        check("frameEnds", rows[k].frames, endCnt);
        check("burstDone", 1, doneCnt);
      end
    end
    // Row nine: reserved, null and escape elements skipped before one request
    check("reqCount", 1, reqCnt);
    check("reqSlots", 8'h07, gotSlots);
    check("reqSid", 16'habcd, gotSid);
    // Row ten: privacy skipped, suppression then acknowledge decoded
    check("ackCount", 1, ackCnt);
    check("ackSid", 16'h1234, ackSid);
    check("phsCount", 1, phsCnt);
    check("ugsCount", 1, ugsCnt);
    check("phsIndex", 8'h09, phsIndex);
    check("ugsByte", 8'h3c, ugsByte);
    check("firstByte", 8'hc3, gotByte);
    rst_n = 1'b0;
    @(posedge sys_clk);
    #1;
    check("framesSeen", 0, framesSeen);
    check("outValid", 0, outValid);
    check("ackSid", 0, ackSid);
    rst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check("errFlags", 0, errFlags);
    check("outValid", 0, outValid);
    wrap_up();
  end
endmodule
`default_nettype wire

// ### verilog/mcehf_elem_if.sv
// Byte feed and decoded results between framer and element parser
`timescale 1ns/100ps
`default_nettype none
interface mcehf_elem_if;
  logic [7:0] elemByte;
  logic elemValid;
  logic elemFirst;
  logic elemLast;
  logic reqValid;
  logic [7:0] reqSlots;
  logic [15:0] reqSid;
  logic ackValid;
  logic [15:0] ackSid;
  logic phsValid;
  logic [7:0] phsIndex;
  logic ugsValid;
  logic [7:0] ugsByte;
  logic elemErr;
  modport src (output elemByte, elemValid, elemFirst, elemLast,
    input reqValid, reqSlots, reqSid, ackValid, ackSid, phsValid, phsIndex, ugsValid, ugsByte, elemErr);
  modport sink (input elemByte, elemValid, elemFirst, elemLast,
    output reqValid, reqSlots, reqSid, ackValid, ackSid, phsValid, phsIndex, ugsValid, ugsByte, elemErr);
endinterface
`default_nettype wire

// ### verilog/mcehf_elem_parser.sv
// Walks extended header elements and decodes the known ones
`timescale 1ns/100ps
`default_nettype none
module mcehf_elem_parser (
  input wire logic sys_clk,
  input wire logic rst_n,
  mcehf_elem_if.sink eif
);
  import mcehf_pkg::*;

  logic hdrPend_q;
  logic [3:0] typ_q;
  logic [3:0] len_q;
  logic [3:0] left_q;
  logic [1:0] idx_q;
  logic [7:0] val_q [0:1];
  logic [3:0] bTyp;
  logic [3:0] bLen;
  logic hdrByte;
  logic valByte;
  logic lastVal;

  assign bTyp = eif.elemByte[ELEM_TYPE_MSB:ELEM_TYPE_LSB];
  assign bLen = eif.elemByte[ELEM_LEN_MSB:ELEM_LEN_LSB];
  assign hdrByte = eif.elemValid && (eif.elemFirst || hdrPend_q);
  assign valByte = eif.elemValid && !eif.elemFirst && !hdrPend_q;
  assign lastVal = valByte && (left_q == 4'h1);

  // ----------------------------------------
  // Element walk
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hdrPend_q <= 1'b1;
      typ_q <= 4'h0;
      len_q <= 4'h0;
      left_q <= 4'h0;
      idx_q <= 2'h0;
      val_q[0] <= 8'h00;
      val_q[1] <= 8'h00;
    end
    else if (hdrByte)
    begin
      typ_q <= bTyp;
      len_q <= bLen;
      left_q <= bLen;
      idx_q <= 2'h0;
      hdrPend_q <= (bLen == 4'h0);
    end
    else if (valByte)
    begin
      // Unknown, reserved and escape values are stepped over by count
      if (idx_q != 2'h2)
      begin
        val_q[idx_q[0]] <= eif.elemByte;
        idx_q <= idx_q + 2'h1;
      end
      left_q <= left_q - 4'h1;
      hdrPend_q <= (left_q == 4'h1);
    end
  end

  // ----------------------------------------
  // Decoded results, one-cycle pulses
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eif.reqValid <= 1'b0;
      eif.reqSlots <= 8'h00;
      eif.reqSid <= 16'h0000;
      eif.ackValid <= 1'b0;
      eif.ackSid <= 16'h0000;
      eif.phsValid <= 1'b0;
      eif.phsIndex <= 8'h00;
      eif.ugsValid <= 1'b0;
      eif.ugsByte <= 8'h00;
      eif.elemErr <= 1'b0;
    end
    else
    begin
      eif.reqValid <= lastVal && typ_q == ELEM_REQ && len_q == ELEM_REQ_LEN;
      eif.ackValid <= lastVal && typ_q == ELEM_ACK && len_q == ELEM_ACK_LEN;
      eif.phsValid <= lastVal && (typ_q == ELEM_PHS_DN || typ_q == ELEM_PHS_UP) &&
        (len_q == ELEM_PHS_LEN || (typ_q == ELEM_PHS_UP && len_q == ELEM_UGS_LEN));
      eif.ugsValid <= lastVal && typ_q == ELEM_PHS_UP && len_q == ELEM_UGS_LEN;
      eif.elemErr <= (hdrByte && ((bTyp == ELEM_NULL && bLen != 4'h0) ||
        (eif.elemLast && bLen != 4'h0))) || (valByte && eif.elemLast && left_q != 4'h1);
      if (lastVal)
      begin
        if (typ_q == ELEM_REQ)
        begin
          eif.reqSlots <= val_q[0];
          eif.reqSid <= {val_q[1], eif.elemByte};
        end
        if (typ_q == ELEM_ACK)
          eif.ackSid <= {val_q[0], eif.elemByte};
        // Held suppression values change only on suppression elements
        if (typ_q == ELEM_PHS_DN || typ_q == ELEM_PHS_UP)
        begin
          if (len_q == ELEM_PHS_LEN)
            eif.phsIndex <= eif.elemByte;
          else
          begin
            eif.phsIndex <= val_q[0];
            eif.ugsByte <= eif.elemByte;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_req_source;
    @(posedge sys_clk) disable iff (!rst_n)
    eif.reqValid |-> typ_q == ELEM_REQ && len_q == ELEM_REQ_LEN && $past(left_q) == 4'h1;
  endproperty
  a_req_source: assert property (p_req_source) else $error("request without full type 1 element");

  property p_null_len;
    @(posedge sys_clk) disable iff (!rst_n)
    hdrByte && bTyp == ELEM_NULL && bLen != 4'h0 |=> eif.elemErr;
  endproperty
  a_null_len: assert property (p_null_len) else $error("null element with length not flagged");

  property p_skip_len;
    @(posedge sys_clk) disable iff (!rst_n)
    hdrByte && bLen != 4'h0 |=> !hdrPend_q && left_q == $past(bLen) && typ_q == $past(bTyp);
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("element length not taken for skip");
endmodule
`default_nettype wire

// ### verilog/mcehf_pkg.sv
// Constants and types for the concatenation and extended header framer
//
// Contract
// - Concat header: type 11, param 11100, no extension
// - Nonzero frame_count equals enclosed frame count
// - byte_count_field sums all enclosed frame lengths
// - Concatenation never sent downstream
// - One concat header per burst, never nested
// - Frames follow back to back, found by length
// - Accept mixed frames, forward each as single
// - Extension present: header_param_byte is ext_header_len
// - Extended header spans 1 to 240 bytes
// - Timing, request, concat headers carry no extension
// - Enclosed frames may carry own extended header
// - byte_count_field counts extension plus payload
// - Element: type, length byte, then 0-15 value bytes
// - Unknown elements skipped using element_len
// - Reserved and escape types ignored, not errors
// - Null element has zero length, may repeat
// - Types 1 and 2: request and acknowledge
// - Types 3 and 4: privacy elements
// - Types 5 and 6: suppression bytes
// - Types 10-14 stay attached when forwarded
// - Type 15 escape carries own type and length
`default_nettype none
package mcehf_pkg;
  // ----------------------------------------
  // Frame control layout
  // ----------------------------------------
  localparam int FRAME_CONTROL_TYPE_MSB = 7;
  localparam int FRAME_CONTROL_TYPE_LSB = 6;
  localparam int FC_PARAM_MSB = 5;
  localparam int FC_PARAM_LSB = 1;
  localparam int FC_EXT_HEADER_BIT = 0;
  localparam logic [1:0] FRAME_CONTROL_TYPE_MAC_SPEC = 2'h3;
  localparam logic [4:0] FC_PARAM_TIMING = 5'h00;
  localparam logic [4:0] FC_PARAM_REQUEST = 5'h02;
  localparam logic [4:0] FC_PARAM_CONCAT = 5'h1c;
  localparam int HDR_BASE_BYTES = 6;
  localparam int EXT_HDR_MIN = 1;
  localparam int EXT_HDR_MAX = 240;
  // ----------------------------------------
  // Element layout and types
  // ----------------------------------------
  localparam int ELEM_TYPE_MSB = 7;
  localparam int ELEM_TYPE_LSB = 4;
  localparam int ELEM_LEN_MSB = 3;
  localparam int ELEM_LEN_LSB = 0;
  localparam logic [3:0] ELEM_NULL = 4'h0;
  localparam logic [3:0] ELEM_REQ = 4'h1;
  localparam logic [3:0] ELEM_ACK = 4'h2;
  localparam logic [3:0] ELEM_PHS_DN = 4'h5;
  localparam logic [3:0] ELEM_PHS_UP = 4'h6;
  localparam logic [3:0] ELEM_REQ_LEN = 4'h3;
  localparam logic [3:0] ELEM_ACK_LEN = 4'h2;
  localparam logic [3:0] ELEM_PHS_LEN = 4'h1;
  localparam logic [3:0] ELEM_UGS_LEN = 4'h2;
  // ----------------------------------------
  // Error flag positions
  // ----------------------------------------
  localparam int ERR_DOWNSTREAM = 0;
  localparam int ERR_NESTED = 1;
  localparam int ERR_FORBID_EXT = 2;
  localparam int ERR_EXT_LEN = 3;
  localparam int ERR_LEN = 4;
  localparam int ERR_COUNT = 5;
  localparam int ERR_ELEM = 6;
  localparam int ERR_WIDTH = 8;

  typedef enum logic [3:0] {
    ST_HDR = 4'h1,
    ST_EXT = 4'h2,
    ST_HCS = 4'h4,
    ST_BODY = 4'h8
  } mcehf_state_t;
endpackage
`default_nettype wire

// ### verilog/mcehf_rx_framer.sv
// Upstream burst receiver: splits concatenations and checks MAC headers
`timescale 1ns/100ps
`default_nettype none
module mcehf_rx_framer #(
  parameter int MAX_EXT_HDR = mcehf_pkg::EXT_HDR_MAX
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  input wire logic burstStart,
  input wire logic dirDownstream,
  output logic [7:0] outByte,
  output logic outValid,
  output logic outFrameStart,
  output logic outFrameEnd,
  output logic burstDone,
  output logic [7:0] framesSeen,
  output logic [mcehf_pkg::ERR_WIDTH-1:0] errFlags,
  output logic reqValid,
  output logic [7:0] reqSlots,
  output logic [15:0] reqSid,
  output logic ackValid,
  output logic [15:0] ackSid,
  output logic phsValid,
  output logic [7:0] phsIndex,
  output logic ugsValid,
  output logic [7:0] ugsByte
);
  import mcehf_pkg::*;

  if (MAX_EXT_HDR < EXT_HDR_MIN || MAX_EXT_HDR > 255)
  begin : g_chk
    $error("MAX_EXT_HDR must be 1 to 255");
  end

  localparam logic [7:0] MAX_EXT8 = MAX_EXT_HDR[7:0];

  // ----------------------------------------
  // Header decode helpers
  // ----------------------------------------
  function automatic logic isConcatFc(input logic [7:0] fc);
    return fc[FRAME_CONTROL_TYPE_MSB:FRAME_CONTROL_TYPE_LSB] == FRAME_CONTROL_TYPE_MAC_SPEC &&
      fc[FC_PARAM_MSB:FC_PARAM_LSB] == FC_PARAM_CONCAT &&
      !fc[FC_EXT_HEADER_BIT];
  endfunction

  function automatic logic noExtKind(input logic [7:0] fc);
    logic [4:0] p;
    p = fc[FC_PARAM_MSB:FC_PARAM_LSB];
    return fc[FRAME_CONTROL_TYPE_MSB:FRAME_CONTROL_TYPE_LSB] == FRAME_CONTROL_TYPE_MAC_SPEC &&
      (p == FC_PARAM_TIMING || p == FC_PARAM_REQUEST || p == FC_PARAM_CONCAT);
  endfunction

  function automatic logic [15:0] bodyLen(input logic [7:0] fc, input logic [7:0] parm,
    input logic [15:0] len);
    logic [15:0] b;
    b = len;
    if (noExtKind(fc) && fc[FC_PARAM_MSB:FC_PARAM_LSB] != FC_PARAM_TIMING)
      b = 16'h0000;
    else if (fc[FC_EXT_HEADER_BIT])
      b = (len < {8'h00, parm}) ? 16'h0000 : len - {8'h00, parm};
    return b;
  endfunction

  mcehf_state_t state_q;
  mcehf_state_t effState;
  logic [1:0] hdrIdx_q;
  logic [1:0] effIdx;
  logic hcsIdx_q;
  logic [7:0] fc_q;
  logic [7:0] parm_q;
  logic [15:0] len_q;
  logic [15:0] fullLen;
  logic [7:0] extLeft_q;
  logic [15:0] bodyLeft_q;
  logic concatHdr_q;
  logic inConcat_q;
  logic [15:0] concatLeft_q;
  logic [7:0] concatCnt_q;
  logic [7:0] framesSeen_q;
  logic [7:0] framesNext;
  logic burstDone_q;
  logic [ERR_WIDTH-1:0] errFlags_q;
  logic [ERR_WIDTH-1:0] errSet;
  logic hdr0;
  logic hdr3;
  logic newConcat;
  logic curConcatHdr;
  logic frameEnd;
  logic concatEnd;
  logic concatHdrEnd;
  logic badExtLen;
  logic [7:0] outByte_q;
  logic outValid_q;
  logic outFrameStart_q;
  logic outFrameEnd_q;

  mcehf_elem_if eif ();

  // A burst start aborts any frame in progress and reads a fresh header
  assign effState = burstStart ? ST_HDR : state_q;
  assign effIdx = burstStart ? 2'h0 : hdrIdx_q;
  assign hdr0 = rxValid && effState == ST_HDR && effIdx == 2'h0;
  assign hdr3 = rxValid && effState == ST_HDR && effIdx == 2'h3;
  assign fullLen = {len_q[15:8], rxByte};
  assign newConcat = hdr0 && burstStart && isConcatFc(rxByte);
  assign curConcatHdr = hdr0 ? newConcat : concatHdr_q;
  assign frameEnd = rxValid && ((effState == ST_HCS && hcsIdx_q && bodyLeft_q == 16'h0000) ||
    (effState == ST_BODY && bodyLeft_q == 16'h0001));
  assign concatHdrEnd = frameEnd && concatHdr_q;
  assign concatEnd = rxValid && !burstStart && inConcat_q && concatLeft_q == 16'h0001;
  assign framesNext = framesSeen_q + ((frameEnd && inConcat_q) ? 8'h01 : 8'h00);
  assign badExtLen = fc_q[FC_EXT_HEADER_BIT] && (parm_q < 8'(EXT_HDR_MIN) || parm_q > MAX_EXT8);

  // ----------------------------------------
  // Header and body walk
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_HDR;
      hdrIdx_q <= 2'h0;
      hcsIdx_q <= 1'b0;
      fc_q <= 8'h00;
      parm_q <= 8'h00;
      len_q <= 16'h0000;
      extLeft_q <= 8'h00;
      bodyLeft_q <= 16'h0000;
      concatHdr_q <= 1'b0;
    end
    else if (rxValid)
    begin
      case (effState)
        ST_HDR:
        begin
          hdrIdx_q <= effIdx + 2'h1;
          hcsIdx_q <= 1'b0;
          case (effIdx)
            2'h0:
            begin
              fc_q <= rxByte;
              concatHdr_q <= newConcat;
            end
            2'h1: parm_q <= rxByte;
            2'h2: len_q[15:8] <= rxByte;
            default:
            begin
              len_q[7:0] <= rxByte;
              extLeft_q <= parm_q;
              bodyLeft_q <= bodyLen(fc_q, parm_q, fullLen);
              // Enclosed frames may carry their own extension
              if (fc_q[FC_EXT_HEADER_BIT] && !noExtKind(fc_q) && !badExtLen)
                state_q <= ST_EXT;
              else
                state_q <= ST_HCS;
            end
          endcase
        end
        ST_EXT:
        begin
          extLeft_q <= extLeft_q - 8'h01;
          if (extLeft_q == 8'h01)
            state_q <= ST_HCS;
        end
        ST_HCS:
        begin
          hcsIdx_q <= 1'b1;
          if (hcsIdx_q)
            state_q <= (bodyLeft_q == 16'h0000) ? ST_HDR : ST_BODY;
        end
        ST_BODY:
        begin
          bodyLeft_q <= bodyLeft_q - 16'h0001;
          if (bodyLeft_q == 16'h0001)
            state_q <= ST_HDR;
        end
        default: state_q <= ST_HDR;
      endcase
    end
  end

  // ----------------------------------------
  // Concatenation tracking
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inConcat_q <= 1'b0;
      concatLeft_q <= 16'h0000;
      concatCnt_q <= 8'h00;
      framesSeen_q <= 8'h00;
      burstDone_q <= 1'b0;
    end
    else
    begin
      burstDone_q <= concatEnd;
      if (rxValid && burstStart)
      begin
        inConcat_q <= 1'b0;
        framesSeen_q <= 8'h00;
      end
      else if (concatHdrEnd)
      begin
        inConcat_q <= len_q != 16'h0000;
        concatLeft_q <= len_q;
        concatCnt_q <= parm_q;
        framesSeen_q <= 8'h00;
      end
      else if (rxValid && inConcat_q)
      begin
        concatLeft_q <= concatLeft_q - 16'h0001;
        framesSeen_q <= framesNext;
        if (concatLeft_q == 16'h0001)
          inConcat_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Error flags, sticky for one burst
  // ----------------------------------------
  always_comb
  begin
    errSet = '0;
    errSet[ERR_DOWNSTREAM] = newConcat && dirDownstream;
    errSet[ERR_NESTED] = hdr0 && !burstStart && isConcatFc(rxByte);
    errSet[ERR_FORBID_EXT] = hdr3 && noExtKind(fc_q) && fc_q[FC_EXT_HEADER_BIT];
    errSet[ERR_EXT_LEN] = hdr3 && !noExtKind(fc_q) && badExtLen;
    errSet[ERR_LEN] = (hdr3 && fc_q[FC_EXT_HEADER_BIT] && !noExtKind(fc_q) && fullLen < {8'h00, parm_q}) ||
      (concatEnd && !frameEnd) || (concatHdrEnd && len_q == 16'h0000);
    errSet[ERR_COUNT] = concatEnd && concatCnt_q != 8'h00 && concatCnt_q != framesNext;
    errSet[ERR_ELEM] = eif.elemErr;
  end

  // New events win over the clear done at burst start
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      errFlags_q <= '0;
    else
      errFlags_q <= ((rxValid && burstStart) ? '0 : errFlags_q) | errSet;
  end

  // ----------------------------------------
  // Frame forwarding
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outByte_q <= 8'h00;
      outValid_q <= 1'b0;
      outFrameStart_q <= 1'b0;
      outFrameEnd_q <= 1'b0;
    end
    else
    begin
      // Every frame leaves whole, extension elements included
      outValid_q <= rxValid && !curConcatHdr;
      outByte_q <= rxByte;
      outFrameStart_q <= hdr0 && !curConcatHdr;
      outFrameEnd_q <= frameEnd && !curConcatHdr;
    end
  end

  // ----------------------------------------
  // Extended header element parser
  // ----------------------------------------
  assign eif.elemByte = rxByte;
  assign eif.elemValid = rxValid && effState == ST_EXT;
  assign eif.elemFirst = extLeft_q == parm_q;
  assign eif.elemLast = extLeft_q == 8'h01;

  mcehf_elem_parser u_elem (
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .eif (eif.sink)
  );

  assign outByte = outByte_q;
  assign outValid = outValid_q;
  assign outFrameStart = outFrameStart_q;
  assign outFrameEnd = outFrameEnd_q;
  assign burstDone = burstDone_q;
  assign framesSeen = framesSeen_q;
  assign errFlags = errFlags_q;
  assign reqValid = eif.reqValid;
  assign reqSlots = eif.reqSlots;
  assign reqSid = eif.reqSid;
  assign ackValid = eif.ackValid;
  assign ackSid = eif.ackSid;
  assign phsValid = eif.phsValid;
  assign phsIndex = eif.phsIndex;
  assign ugsValid = eif.ugsValid;
  assign ugsByte = eif.ugsByte;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_down_concat;
    @(posedge sys_clk) disable iff (!rst_n)
    rxValid && burstStart && isConcatFc(rxByte) && dirDownstream |=> errFlags_q[ERR_DOWNSTREAM];
  endproperty
  a_down_concat: assert property (p_down_concat) else $error("downstream concatenation not flagged");

  property p_concat_hidden;
    @(posedge sys_clk) disable iff (!rst_n)
    newConcat |=> !outValid_q ##1 (!outValid_q || !rxValid)[*1];
  endproperty
  a_concat_hidden: assert property (p_concat_hidden) else $error("concatenation header forwarded");

  property p_frame_fwd;
    @(posedge sys_clk) disable iff (!rst_n)
    hdr0 && !isConcatFc(rxByte) |=> outValid_q && outFrameStart_q && outByte_q == $past(rxByte);
  endproperty
  a_frame_fwd: assert property (p_frame_fwd) else $error("frame start not forwarded");

  property p_nested;
    @(posedge sys_clk) disable iff (!rst_n)
    hdr0 && !burstStart && isConcatFc(rxByte) |=> errFlags_q[ERR_NESTED] && !concatHdr_q;
  endproperty
  a_nested: assert property (p_nested) else $error("second concatenation not flagged");

  property p_forbid_ext;
    @(posedge sys_clk) disable iff (!rst_n)
    hdr3 && noExtKind(fc_q) && fc_q[FC_EXT_HEADER_BIT] |=> errFlags_q[ERR_FORBID_EXT] && state_q == ST_HCS;
  endproperty
  a_forbid_ext: assert property (p_forbid_ext) else $error("forbidden extension not flagged");

  property p_ext_len;
    @(posedge sys_clk) disable iff (!rst_n)
    hdr3 && !noExtKind(fc_q) && fc_q[FC_EXT_HEADER_BIT] && parm_q > MAX_EXT8 |=> errFlags_q[ERR_EXT_LEN];
  endproperty
  a_ext_len: assert property (p_ext_len) else $error("oversize extension not flagged");

  property p_count;
    @(posedge sys_clk) disable iff (!rst_n)
    burstDone_q && concatCnt_q != 8'h00 && concatCnt_q != framesSeen_q |-> errFlags_q[ERR_COUNT];
  endproperty
  a_count: assert property (p_count) else $error("frame count mismatch not flagged");

  property p_concat_span;
    @(posedge sys_clk) disable iff (!rst_n)
    concatHdrEnd && len_q != 16'h0000 |=> inConcat_q && concatLeft_q == $past(len_q);
  endproperty
  a_concat_span: assert property (p_concat_span) else $error("concatenation span not loaded");
endmodule
`default_nettype wire
